/* File: rtl/tws_pkg.sv */
package tws_pkg;

  // ***************************************
  // timing
  // ***************************************
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned BEXIT_NS      = 250;
  localparam int unsigned BEXIT_CYC     =
    (BEXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          BEXIT_W       = 4;
  localparam logic [BEXIT_W-1:0] BEXIT_CNT = BEXIT_W'(BEXIT_CYC);

  // ***************************************
  // serial register map
  // ***************************************
  localparam logic [6:0] ADR_PID    = 7'h00;
  localparam logic [6:0] ADR_REV    = 7'h01;
  localparam logic [6:0] ADR_MOTION = 7'h02;
  localparam logic [6:0] ADR_DX     = 7'h03;
  localparam logic [6:0] ADR_DY     = 7'h04;
  localparam logic [6:0] ADR_SURFACE_QUALITY  = 7'h05;
  localparam logic [6:0] ADR_SHUT_H = 7'h06;
  localparam logic [6:0] ADR_SHUT_L = 7'h07;
  localparam logic [6:0] ADR_MAXPIX = 7'h08;
  localparam logic [6:0] ADR_PIXSUM = 7'h09;
  localparam logic [6:0] ADR_MCTL   = 7'h0D;
  localparam logic [6:0] ADR_MCTL2  = 7'h19;
  localparam logic [6:0] ADR_LEDDC  = 7'h22;
  localparam logic [6:0] ADR_CRST   = 7'h3A;
  localparam logic [6:0] ADR_PID2   = 7'h3E;
  localparam logic [6:0] ADR_INVREV = 7'h3F;
  localparam logic [6:0] ADR_BURST  = 7'h63;

  localparam logic [7:0] MCTL_RST   = 8'h00;
  localparam logic [7:0] MCTL2_RST  = 8'h08;
  localparam logic [7:0] LEDDC_RST  = 8'h00;
  localparam logic [7:0] CRST_KEY   = 8'h5A;
  localparam int         PD_BIT     = 1;
  localparam int         MOT_BIT    = 7;
  localparam int         LEDDC_BIT  = 0;
  localparam int         DIR_BIT    = 7;

  localparam int         BURST_LEN  = 7;
  localparam int         BIDX_W     = 3;
  localparam logic [BIDX_W-1:0] BIDX_LAST = BIDX_W'(BURST_LEN - 1);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_WDATA = 3'b001,
    ST_RDATA = 3'b010,
    ST_BURST = 3'b011,
    ST_RHOLD = 3'b100
  } tws_state_e;

  // ***************************************
  // bus register map
  // ***************************************
  localparam int              AXI_AW      = 4;
  localparam logic [AXI_AW-1:0] OFS_CTRL  = 4'h0;
  localparam logic [AXI_AW-1:0] OFS_STAT  = 4'h4;
  localparam logic [AXI_AW-1:0] OFS_LASTWR = 4'h8;
  localparam logic [31:0]     CTRL_RST    = 32'h0000_0840;
  localparam int              CTRL_PER_LSB = 0;
  localparam int              CTRL_ON_LSB  = 8;
  localparam int              STAT_PD     = 0;
  localparam int              STAT_LOCK   = 1;
  localparam int              STAT_ST_LSB = 2;
  localparam int              STAT_LED    = 5;
  localparam int              LW_ADDR_LSB = 8;
  localparam logic [1:0]      RESP_OKAY   = 2'b00;
  localparam logic [1:0]      RESP_SLVERR = 2'b10;

endpackage : tws_pkg

/* File: rtl/tws_port.sv */
`timescale 1ns/1ps
`default_nettype none
module tws_port
  import tws_pkg::*;
#(
  parameter logic [7:0] PRODUCT_ID  = 8'hA5, // arbitrary value
  parameter logic [7:0] REVISION_ID = 8'h03, // arbitrary value
  parameter logic [7:0] PRODUCT_ID2 = 8'h5C  // arbitrary value
) (
  input  wire logic              mclk_i,
  input  wire logic              rstn_i,
  input  wire logic              sclk_i,
  input  wire logic              port_select_n_i,
  input  wire logic              sdio_i,
  output logic                   sdio_o,
  output logic                   sdio_oe_o,
  input  wire logic              chip_reset_n_i,
  output logic                   illum_led_drive_o,
  input  wire logic              motion_det_i,
  input  wire logic [7:0]        delta_x_i,
  input  wire logic [7:0]        delta_y_i,
  input  wire logic [7:0]        surface_quality_i,
  input  wire logic [15:0]       shutter_i,
  input  wire logic [7:0]        max_pixel_i,
  input  wire logic [7:0]        pixel_sum_i,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  input  wire logic [AXI_AW-1:0] s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i
);

  // ***************************************
  // pin synchronisers and edges
  // ***************************************
  logic sclk_s, cs_n_s, sdio_s, crst_n_s, sclk_d_reg;
  tws_sync #(.W(4)) u_sync (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .d_i    ({sclk_i, port_select_n_i, sdio_i, chip_reset_n_i}),
    .q_o    ({sclk_s, cs_n_s, sdio_s, crst_n_s})
  );

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) sclk_d_reg <= 1'b1;
    else         sclk_d_reg <= sclk_s;
  end

  logic sclk_rise, sclk_fall, soft_rst_reg, core_rst, active;
  assign sclk_rise = sclk_s & ~sclk_d_reg;
  assign sclk_fall = ~sclk_s & sclk_d_reg;
  assign core_rst  = !rstn_i || !crst_n_s || soft_rst_reg;
  assign active    = !core_rst && !cs_n_s;

  // ***************************************
  // command decode
  // ***************************************
  tws_state_e        state_reg;
  logic [2:0]        bitcnt_reg;
  logic [7:0]        sh_reg, cmd_reg, tx_reg, rd_byte;
  logic [BIDX_W-1:0] idx_reg;
  logic              lock_reg;
  logic [7:0]        buf_reg [BURST_LEN];
  logic [7:0]        cmd;
  logic              in_bit, byte_end, addr_done, rd_start, wr_done;
  logic              data_end, burst_start, burst_next;

  assign cmd         = {sh_reg[6:0], sdio_s};
  assign in_bit      = active && sclk_rise;
  assign byte_end    = in_bit && bitcnt_reg == 3'd7;
  assign addr_done   = byte_end && state_reg == ST_IDLE && !lock_reg;
  assign rd_start    = addr_done && !cmd[DIR_BIT];
  assign wr_done     = byte_end && state_reg == ST_WDATA;
  assign data_end    = byte_end &&
                       (state_reg == ST_RDATA || state_reg == ST_BURST);
  assign burst_start = rd_start && cmd[6:0] == ADR_BURST;
  assign burst_next  = data_end && state_reg == ST_BURST &&
                       idx_reg != BIDX_LAST;

  // ***************************************
  // serial state machine
  // ***************************************
  always_ff @(posedge mclk_i) begin
    if (!active) begin
      state_reg  <= ST_IDLE;
      bitcnt_reg <= 3'd0;
      sh_reg     <= 8'h00;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (sclk_rise && !lock_reg) begin
            sh_reg     <= cmd;
            bitcnt_reg <= bitcnt_reg + 3'd1;
            if (addr_done) begin
              if (cmd[DIR_BIT]) state_reg <= ST_WDATA;
              else if (burst_start) state_reg <= ST_BURST;
              else state_reg <= ST_RDATA;
            end
          end
        end
        ST_WDATA: begin
          if (sclk_rise) begin
            sh_reg     <= cmd;
            bitcnt_reg <= bitcnt_reg + 3'd1;
            if (wr_done) state_reg <= ST_IDLE;
          end
        end
        ST_RDATA, ST_BURST: begin
          if (sclk_rise) begin
            bitcnt_reg <= bitcnt_reg + 3'd1;
            if (data_end && !burst_next) state_reg <= ST_RHOLD;
          end
        end
        ST_RHOLD: begin
          if (sclk_fall) state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) cmd_reg <= 8'h00;
    else if (addr_done) cmd_reg <= cmd;
  end

  // ***************************************
  // burst capture and exit lock
  // ***************************************
  always_ff @(posedge mclk_i) begin
    if (burst_start) begin
      buf_reg[0] <= delta_x_i;
      buf_reg[1] <= delta_y_i;
      buf_reg[2] <= surface_quality_i;
      buf_reg[3] <= shutter_i[15:8];
      buf_reg[4] <= shutter_i[7:0];
      buf_reg[5] <= max_pixel_i;
      buf_reg[6] <= pixel_sum_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (core_rst || burst_start) idx_reg <= '0;
    else if (burst_next) idx_reg <= idx_reg + 3'd1;
  end

  logic [BEXIT_W-1:0] exit_cnt_reg;
  always_ff @(posedge mclk_i) begin
    if (core_rst) begin
      lock_reg     <= 1'b0;
      exit_cnt_reg <= '0;
    end else if (burst_start) begin
      lock_reg     <= 1'b1;
      exit_cnt_reg <= '0;
    end else if (!cs_n_s) begin
      exit_cnt_reg <= '0;
    end else if (lock_reg) begin
      exit_cnt_reg <= exit_cnt_reg + 4'd1;
      if (exit_cnt_reg == BEXIT_CNT - 4'd1) lock_reg <= 1'b0;
    end
  end

  // ***************************************
  // serial registers
  // ***************************************
  logic [7:0] mctl_reg, mctl2_reg, leddc_reg;
  logic [7:0] lw_addr_reg, lw_data_reg;
  logic       pd_reg;

  always_ff @(posedge mclk_i) begin
    if (core_rst) begin
      mctl_reg  <= MCTL_RST;
      mctl2_reg <= MCTL2_RST;
      leddc_reg <= LEDDC_RST;
      pd_reg    <= 1'b0;
    end else if (wr_done) begin
      case (cmd_reg[6:0])
        ADR_MCTL: begin
          mctl_reg <= cmd;
          if (cmd[PD_BIT]) pd_reg <= 1'b1;
        end
        ADR_MCTL2: mctl2_reg <= cmd;
        ADR_LEDDC: leddc_reg <= cmd;
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      soft_rst_reg <= 1'b0;
      lw_addr_reg  <= 8'h00;
      lw_data_reg  <= 8'h00;
    end else begin
      soft_rst_reg <= wr_done && cmd_reg[6:0] == ADR_CRST &&
                      cmd == CRST_KEY;
      if (wr_done) begin
        lw_addr_reg <= cmd_reg;
        lw_data_reg <= cmd;
      end
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    case (cmd[6:0])
      ADR_PID:    rd_byte = PRODUCT_ID;
      ADR_REV:    rd_byte = REVISION_ID;
      ADR_MOTION: rd_byte[MOT_BIT] = motion_det_i;
      ADR_DX:     rd_byte = delta_x_i;
      ADR_DY:     rd_byte = delta_y_i;
      ADR_SURFACE_QUALITY:  rd_byte = surface_quality_i;
      ADR_SHUT_H: rd_byte = shutter_i[15:8];
      ADR_SHUT_L: rd_byte = shutter_i[7:0];
      ADR_MAXPIX: rd_byte = max_pixel_i;
      ADR_PIXSUM: rd_byte = pixel_sum_i;
      ADR_MCTL:   rd_byte = mctl_reg;
      ADR_MCTL2:  rd_byte = mctl2_reg;
      ADR_LEDDC:  rd_byte = leddc_reg;
      ADR_PID2:   rd_byte = PRODUCT_ID2;
      ADR_INVREV: rd_byte = ~REVISION_ID;
      ADR_BURST:  rd_byte = delta_x_i; // first byte of the stream
      default:    rd_byte = 8'h00;
    endcase
  end

  // ***************************************
  // data line driver
  // ***************************************
  always_ff @(posedge mclk_i) begin
    if (!active) begin
      sdio_oe_o <= 1'b0;
      sdio_o    <= 1'b0;
      tx_reg    <= 8'h00;
    end else if (rd_start) begin
      tx_reg <= rd_byte;
    end else if (burst_next) begin
      tx_reg <= buf_reg[idx_reg + 3'd1];
    end else if (sclk_fall) begin
      if (state_reg == ST_RDATA || state_reg == ST_BURST) begin
        sdio_oe_o <= 1'b1;
        sdio_o    <= tx_reg[7];
        tx_reg    <= {tx_reg[6:0], 1'b0};
      end else begin
        sdio_oe_o <= 1'b0;
      end
    end
  end

  // ***************************************
  // illumination drive
  // ***************************************
  logic [31:0] ctrl_reg;
  logic [7:0]  led_cnt_reg, led_per, led_on;
  assign led_per = ctrl_reg[CTRL_PER_LSB +: 8];
  assign led_on  = ctrl_reg[CTRL_ON_LSB +: 8];

  always_ff @(posedge mclk_i) begin
    if (!rstn_i || led_cnt_reg >= led_per) led_cnt_reg <= 8'h00;
    else led_cnt_reg <= led_cnt_reg + 8'h01;
  end

  always_ff @(posedge mclk_i) begin
    if (core_rst || pd_reg) illum_led_drive_o <= 1'b0;
    else illum_led_drive_o <= leddc_reg[LEDDC_BIT] || motion_det_i ||
                              led_cnt_reg < led_on;
  end

  // ***************************************
  // AXI4-Lite slave
  // ***************************************
  logic [31:0]       wdata_reg, rmux;
  logic [3:0]        wstrb_reg;
  logic [AXI_AW-1:0] awaddr_reg;
  logic              aw_full_reg, w_full_reg;

  assign s_axi_awready_o = !aw_full_reg && !s_axi_bvalid_o;
  assign s_axi_wready_o  = !w_full_reg && !s_axi_bvalid_o;
  assign s_axi_arready_o = !s_axi_rvalid_o;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      aw_full_reg    <= 1'b0;
      w_full_reg     <= 1'b0;
      awaddr_reg     <= '0;
      wdata_reg      <= '0;
      wstrb_reg      <= '0;
      ctrl_reg       <= CTRL_RST;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_full_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_full_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata_i;
        wstrb_reg  <= s_axi_wstrb_i;
      end
      if (aw_full_reg && w_full_reg) begin
        aw_full_reg    <= 1'b0;
        w_full_reg     <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= RESP_OKAY;
        if (awaddr_reg == OFS_CTRL) begin
          for (int b = 0; b < 4; b++) begin
            if (wstrb_reg[b]) ctrl_reg[b*8 +: 8] <= wdata_reg[b*8 +: 8];
          end
        end else if (awaddr_reg != OFS_STAT && awaddr_reg != OFS_LASTWR) begin
          s_axi_bresp_o <= RESP_SLVERR;
        end
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  always_comb begin
    rmux = 32'h0000_0000;
    case (s_axi_araddr_i)
      OFS_CTRL: rmux = ctrl_reg;
      OFS_STAT: begin
        rmux[STAT_PD]            = pd_reg;
        rmux[STAT_LOCK]          = lock_reg;
        rmux[STAT_ST_LSB +: 3]   = state_reg;
        rmux[STAT_LED]           = illum_led_drive_o;
      end
      OFS_LASTWR: rmux[15:0] = {lw_addr_reg, lw_data_reg};
      default: rmux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= '0;
      s_axi_rresp_o  <= RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o  <= rmux;
      s_axi_rresp_o  <= (s_axi_araddr_i == OFS_CTRL ||
                         s_axi_araddr_i == OFS_STAT ||
                         s_axi_araddr_i == OFS_LASTWR) ?
                        RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // ***************************************
  // checks
  // ***************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  sel_release_a: assert property (cs_n_s |=> !sdio_oe_o)
    else $error("data line driven while deselected");
  abort_idle_a: assert property (cs_n_s |=>
    state_reg == ST_IDLE && bitcnt_reg == 3'd0)
    else $error("port not idle after select rise");
  drive_only_read_a: assert property (sdio_oe_o |->
    state_reg == ST_RDATA || state_reg == ST_BURST || state_reg == ST_RHOLD)
    else $error("data line driven outside a read");
  write_dir_a: assert property (addr_done && cmd[DIR_BIT] |=>
    state_reg == ST_WDATA)
    else $error("write address did not enter data phase");
  read_drive_a: assert property (sclk_fall && active &&
    (state_reg == ST_RDATA || state_reg == ST_BURST) |=>
    sdio_oe_o && sdio_o == $past(tx_reg[7]))
    else $error("read bit not driven on falling edge");
  bit_hold_a: assert property (active && !sclk_fall |=>
    $stable(sdio_o))
    else $error("read bit changed before falling edge");
  rise_sample_a: assert property (in_bit && state_reg == ST_WDATA &&
    bitcnt_reg != 3'd7 |=> sh_reg[0] == $past(sdio_s))
    else $error("data not shifted on rising edge");
  burst_order_a: assert property (burst_start |=>
    buf_reg[1] == $past(delta_y_i) && buf_reg[6] == $past(pixel_sum_i))
    else $error("burst capture order wrong");
  burst_lock_a: assert property (lock_reg && !cs_n_s &&
    state_reg == ST_IDLE |=> state_reg == ST_IDLE)
    else $error("port accepted traffic during burst lock");
  burst_exit_a: assert property (lock_reg ##0 cs_n_s [*7] |=>
    !lock_reg)
    else $error("burst lock held past exit time");
  reset_cmd_a: assert property (wr_done &&
    cmd_reg[6:0] == ADR_CRST && cmd == CRST_KEY |=>
    ##1 !pd_reg && mctl2_reg == MCTL2_RST)
    else $error("reset command did not reset");
  pd_led_a: assert property (pd_reg |=> !illum_led_drive_o)
    else $error("LED on during power-down");
  led_dc_a: assert property (!core_rst && !pd_reg &&
    leddc_reg[LEDDC_BIT] |=> illum_led_drive_o)
    else $error("forced LED drive not on");

endmodule : tws_port
`default_nettype wire

/* File: rtl/tws_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module tws_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_reg;

  // ***************************************
  // two-stage synchroniser, idles high
  // ***************************************
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      meta_reg <= '1;
      q_o      <= '1;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end

endmodule : tws_sync
`default_nettype wire

/* File: sim/tws_host.sv */
`timescale 1ns/1ps
`default_nettype none
module tws_host #(
  parameter int AD_GAP = 100,
  parameter int WR_GAP = 500,
  parameter int RD_GAP = 13,
  parameter int EXIT   = 8
) (
  input  wire logic mclk_i,
  input  wire logic sdio_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      d_o
);
  // ****
  // serial master
  // ****
  initial sclk_o = 1'b1;
  initial cs_n_o = 1'b1;
  initial d_o = 1'b0;
  task automatic hc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : hc
  task automatic tx(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      hc(4);
      sclk_o <= 1'b0;
      d_o    <= b[i];
      hc(4);
      sclk_o <= 1'b1;
    end
  endtask : tx
  // released line never shows the last value
  task automatic rel();
    hc(4);
    d_o <= ~d_o;
  endtask : rel
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    hc(1);
    cs_n_o <= 1'b0;
    tx({1'b1, a});
    tx(d);
    rel();
    cs_n_o <= 1'b1;
    hc(WR_GAP);
  endtask : wr
  task automatic rd(input logic [6:0] a, input int n, output logic [55:0] v);
    v = '0;
    hc(1);
    cs_n_o <= 1'b0;
    tx({1'b0, a});
    rel();
    hc(AD_GAP);
    for (int k = 0; k < n; k++) begin
      repeat (8) begin
        hc(2);
        sclk_o <= 1'b0;
        hc(4);
        sclk_o <= 1'b1;
        hc(2);
        v = {v[54:0], sdio_i};
      end
    end
    hc(RD_GAP);
    cs_n_o <= 1'b1;
    hc(EXIT);
  endtask : rd
  task automatic abort();
    hc(1);
    cs_n_o <= 1'b0;
    tx(8'hFF);
    cs_n_o <= 1'b1;
    hc(WR_GAP);
  endtask : abort
endmodule : tws_host
`default_nettype wire

/* File: sim/tws_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tws_port_tb import tws_pkg::*;;
  logic mclk_i = 1'b0, rstn_i = 1'b0, chip_reset_n_i = 1'b1;
  logic motion_det_i = 1'b0, s_axi_awvalid_i = 1'b0;
  logic s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic [7:0] delta_x_i = 8'h00, delta_y_i = 8'h00;
  logic [7:0] surface_quality_i = 8'h00, max_pixel_i = 8'h00;
  logic [7:0] pixel_sum_i = 8'h00;
  logic [15:0] shutter_i = 16'h0000;
  logic [3:0] s_axi_awaddr_i = 4'h0, s_axi_araddr_i = 4'h0;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, q;
  logic sclk_i, port_select_n_i, hd, sdio_o, sdio_oe_o;
  logic illum_led_drive_o, s_axi_awready_o, s_axi_wready_o;
  logic s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, r;
  wire logic sdio_i;
  int seed = 32'h4dba, n_fail = 0, check_count = 0, c;
  logic [55:0] v;
  logic [63:0] e;
  logic [7:0] d;
  assign sdio_i = sdio_oe_o ? sdio_o : hd;
  always #20 mclk_i = ~mclk_i;
  tws_port dut (.mclk_i, .rstn_i, .sclk_i, .port_select_n_i, .sdio_i,
    .sdio_o, .sdio_oe_o, .chip_reset_n_i, .illum_led_drive_o,
    .motion_det_i, .delta_x_i, .delta_y_i, .surface_quality_i,
    .shutter_i, .max_pixel_i, .pixel_sum_i, .s_axi_awaddr_i,
    .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i, .s_axi_wready_o,
    .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
    .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
    .s_axi_rvalid_o, .s_axi_rready_i);
  tws_host host (.mclk_i, .sdio_i, .sclk_o(sclk_i),
    .cs_n_o(port_select_n_i), .d_o(hd));
  // ****
  // checks and bus tasks
  // ****
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [63:0] exp_lastwr(input logic [6:0] a,
                                              input logic [7:0] dd);
    return {48'h0, 1'b1, a, dd};
  endfunction : exp_lastwr
  task automatic axw(input logic [3:0] a, input logic [31:0] dd);
    @(posedge mclk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= dd;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    forever begin
      @(posedge mclk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      if (s_axi_bvalid_o) begin
        r = s_axi_bresp_o;
        s_axi_bready_i <= 1'b0;
        break;
      end
    end
  endtask : axw
  task automatic axr(input logic [3:0] a);
    @(posedge mclk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    forever begin
      @(posedge mclk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      if (s_axi_rvalid_o) begin
        q = s_axi_rdata_o;
        r = s_axi_rresp_o;
        s_axi_rready_i <= 1'b0;
        break;
      end
    end
  endtask : axr
  task automatic ledcnt();
    c = 0;
    repeat (256) begin
      @(posedge mclk_i);
      c += int'(illum_led_drive_o === 1'b1);
    end
  endtask : ledcnt
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  initial begin
    repeat (40000) @(posedge mclk_i);
    n_fail++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge mclk_i);
    rstn_i <= 1'b1;
    host.hc(4);
    axr(OFS_CTRL);
    chk(64'(q), 64'(CTRL_RST));
    axw(OFS_CTRL, 32'h0000_0420);
    axr(OFS_CTRL);
    chk(64'(q[15:0]), 64'h0420);
    axr(4'hC);
    chk({q, 30'h0, r}, {32'h0, 30'h0, RESP_SLVERR});
    axw(4'hC, 32'h1);
    chk(64'(r), 64'(RESP_SLVERR));
    axw(OFS_STAT, 32'h1);
    chk(64'(r), 64'(RESP_OKAY));
    host.rd(ADR_MCTL2, 1, v);
    chk(64'(v[7:0]), 64'(MCTL2_RST));
    repeat (3) begin
      d = 8'($random(seed));
      host.wr(ADR_MCTL2, d);
      host.rd(ADR_MCTL2, 1, v);
      chk(64'(v[7:0]), 64'(d));
      axr(OFS_LASTWR);
      chk(64'(q[15:0]), exp_lastwr(ADR_MCTL2, d));
      chk(64'(sdio_oe_o), 64'h0);
    end
    motion_det_i <= 1'b1;
    host.rd(ADR_MOTION, 1, v);
    chk(64'(v[MOT_BIT]), 64'h1);
    e = {$random(seed), $random(seed)};
    {delta_x_i, delta_y_i, surface_quality_i, shutter_i, max_pixel_i,
     pixel_sum_i} <= e[55:0];
    host.rd(ADR_BURST, 7, v);
    chk(64'(v), 64'(e[55:0]));
    host.rd(ADR_BURST, 1, v);
    chk(64'(v), 64'(e[55:48]));
    host.rd(ADR_SHUT_H, 1, v);
    chk(64'(v[7:0]), 64'(e[31:24]));
    host.abort();
    host.rd(ADR_MCTL2, 1, v);
    chk(64'(v[7:0]), 64'(d));
    ledcnt();
    chk(64'(c), 64'd256);
    motion_det_i <= 1'b0;
    ledcnt();
    chk(64'(c > 0 && c < 256), 64'h1);
    host.wr(ADR_LEDDC, 8'h01);
    ledcnt();
    chk(64'(c), 64'd256);
    host.wr(ADR_MCTL, 8'h02);
    axr(OFS_STAT);
    chk(64'(q[STAT_PD]), 64'h1);
    ledcnt();
    chk(64'(c), 64'd0);
    host.wr(ADR_CRST, CRST_KEY);
    host.hc(100);
    axr(OFS_STAT);
    chk(64'(q[STAT_PD]), 64'h0);
    host.rd(ADR_MCTL2, 1, v);
    chk(64'(v[7:0]), 64'(MCTL2_RST));
    host.wr(ADR_MCTL2, ~MCTL2_RST);
    chip_reset_n_i <= 1'b0;
    host.hc(4);
    chip_reset_n_i <= 1'b1;
    host.hc(100);
    host.rd(ADR_MCTL2, 1, v);
    chk(64'(v[7:0]), 64'(MCTL2_RST));
    complete_run();
  end
endmodule : tws_port_tb
`default_nettype wire
